//--- core/fvs_defines.vh
// register offsets, reset values, field positions and counts for the fec search config block
`ifndef FVS_DEFINES_VH
`define FVS_DEFINES_VH
`define FVS_OFF_MODE      8'h28
`define FVS_OFF_LVL12     8'h29
`define FVS_OFF_LVL23     8'h2a
`define FVS_OFF_LVL34     8'h2b
`define FVS_OFF_LVL56     8'h2c
`define FVS_OFF_LVL78     8'h2d
`define FVS_OFF_PUNC      8'h31
`define FVS_OFF_SCAN      8'h32
`define FVS_RST_MODE      8'h01
`define FVS_RST_LVL12     8'h1e
`define FVS_RST_LVL23     8'h14
`define FVS_RST_LVL34     8'h0f
`define FVS_RST_LVL56     8'h09
`define FVS_RST_LVL78     8'h05
`define FVS_RST_PUNC      8'h1f
`define FVS_RST_SCAN      8'h19
`define FVS_STD_QPSK      4'h0
`define FVS_STD_BPSK      4'h1
`define FVS_STD_ALT       4'h4
`define FVS_MODE_SERIAL   1
`define FVS_MODE_HIZ      0
`define FVS_SCAN_MANUAL   7
`define FVS_SCAN_AVG_LO   4
`define FVS_SCAN_TO_LO    2
`define FVS_SCAN_HYS_LO   0
`define FVS_PUNC_MASK     8'h1f
`define FVS_NUM_RATES     5
`define FVS_BLK_QPSK      8'hcc
`define FVS_BLK_ALT       8'h93
`define FVS_TO_UNIT_LOG2  10
`define FVS_AVG_BASE_LOG2 10
`define FVS_CNT_W         18
`endif

//--- core/fvs_search_timer.v
// sync-word search timeout counter in bit periods
`include "fvs_defines.vh"
module fvs_search_timer (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // control
    input  wire        run,
    input  wire        restart,
    input  wire        bit_tick,
    input  wire [1:0]  limit_sel,
    // result
    output reg         expired
);
    // ==========================================
    // counter, limit = (16 << sel) * 1024 bits
    reg  [`FVS_CNT_W-1:0] cnt_r;
    wire [`FVS_CNT_W-1:0] limit;
    assign limit = {{(`FVS_CNT_W-5){1'b0}}, 5'h10} << (limit_sel + `FVS_TO_UNIT_LOG2);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= {`FVS_CNT_W{1'b0}};
            expired <= 1'b0;
        end else if (restart || !run) begin
            // without sync processing the timer is held idle
            cnt_r   <= {`FVS_CNT_W{1'b0}};
            expired <= 1'b0;
        end else if (bit_tick) begin
            if (cnt_r == limit - 1'b1) begin
                cnt_r   <= {`FVS_CNT_W{1'b0}};
                expired <= 1'b1;
            end else begin
                cnt_r   <= cnt_r + 1'b1;
                expired <= 1'b0;
            end
        end else begin
            expired <= 1'b0;
        end
    end
endmodule

//--- core/fvs_config.v
// fec viterbi and sync search configuration bank with search sequencer
//
// Function
// - fec mode field selects standard and feeding
// - mode bit 1 selects serial output
// - mode bit 0 puts outputs high impedance
// - five rate thresholds with reset values
// - one threshold shared by 7/8 and 6/7
// - five puncture enables, all on after reset
// - scan bit 7 selects manual search
// - averaging field selects error rate span
// - timeout field bounds sync search duration
// - timeout steps to next phase or rate
// - timeout ignored without sync processing
// - hysteresis sets sync counter maximum blocks
// - sync disabled freezes search and byte phase
`include "fvs_defines.vh"
module fvs_config (
    // clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // register port from the serial control interface
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // decoder status
    input  wire       sync_word_enable,
    input  wire       bit_tick,
    input  wire       sync_found,
    // decoder configuration
    output reg  [3:0] std_sel,
    output reg        iq_feed,
    output reg        alt_std,
    output reg        serial_out,
    output reg        stream_oe,
    output reg  [7:0] vit_level,
    output reg  [2:0] rate_sel,
    output reg  [2:0] bit_phase,
    output reg  [17:0] averaging_span,
    output reg  [7:0] sync_hys_max,
    output reg  [7:0] sync_block_len,
    output reg        searching
);
    // ==========================================
    // reset synchroniser
    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    // ==========================================
    // register bank
    reg [7:0] fec_mode_cfg_r;
    reg [7:0] vit_level_r [0:`FVS_NUM_RATES-1];
    reg [7:0] puncture_enable_r;
    reg [7:0] scan_control_r;
    wire [7:0] lvl_off [0:`FVS_NUM_RATES-1];
    wire [7:0] lvl_rst [0:`FVS_NUM_RATES-1];
    assign lvl_off[0] = `FVS_OFF_LVL12;
    assign lvl_off[1] = `FVS_OFF_LVL23;
    assign lvl_off[2] = `FVS_OFF_LVL34;
    assign lvl_off[3] = `FVS_OFF_LVL56;
    assign lvl_off[4] = `FVS_OFF_LVL78;
    assign lvl_rst[0] = `FVS_RST_LVL12;
    assign lvl_rst[1] = `FVS_RST_LVL23;
    assign lvl_rst[2] = `FVS_RST_LVL34;
    assign lvl_rst[3] = `FVS_RST_LVL56;
    assign lvl_rst[4] = `FVS_RST_LVL78;

    genvar gi;
    generate
        for (gi = 0; gi < `FVS_NUM_RATES; gi = gi + 1) begin : g_lvl
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    vit_level_r[gi] <= 8'h00;
                end else if (!rst_s2_r) begin
                    vit_level_r[gi] <= 8'h00;
                end else if (reg_wr && reg_addr == lvl_off[gi]) begin
                    vit_level_r[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    integer k;
    integer j;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fec_mode_cfg_r    <= `FVS_RST_MODE;
            puncture_enable_r <= `FVS_RST_PUNC;
            scan_control_r    <= `FVS_RST_SCAN;
        end else begin
            if (reg_wr && reg_addr == `FVS_OFF_MODE) begin
                // unused bits are kept as written; software keeps them zero
                fec_mode_cfg_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == `FVS_OFF_PUNC) begin
                puncture_enable_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == `FVS_OFF_SCAN) begin
                scan_control_r <= reg_wdata;
            end
        end
    end

    // effective thresholds: reset value until first write after init
    reg [`FVS_NUM_RATES-1:0] lvl_wr_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_wr_r <= {`FVS_NUM_RATES{1'b0}};
        end else begin
            for (k = 0; k < `FVS_NUM_RATES; k = k + 1) begin
                if (reg_wr && reg_addr == lvl_off[k]) begin
                    lvl_wr_r[k] <= 1'b1;
                end
            end
        end
    end
    reg [7:0] lvl_eff [0:`FVS_NUM_RATES-1];
    always @* begin
        for (j = 0; j < `FVS_NUM_RATES; j = j + 1) begin
            lvl_eff[j] = lvl_wr_r[j] ? vit_level_r[j] : lvl_rst[j];
        end
    end

    // read port, unmapped addresses read zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `FVS_OFF_MODE:  reg_rdata <= fec_mode_cfg_r;
                `FVS_OFF_LVL12: reg_rdata <= lvl_eff[0];
                `FVS_OFF_LVL23: reg_rdata <= lvl_eff[1];
                `FVS_OFF_LVL34: reg_rdata <= lvl_eff[2];
                `FVS_OFF_LVL56: reg_rdata <= lvl_eff[3];
                `FVS_OFF_LVL78: reg_rdata <= lvl_eff[4];
                `FVS_OFF_PUNC:  reg_rdata <= puncture_enable_r;
                `FVS_OFF_SCAN:  reg_rdata <= scan_control_r;
                default:        reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // field decode
    wire [3:0] mode_std;
    wire       manual;
    wire [1:0] avg_sel;
    wire [1:0] to_sel;
    wire [1:0] hys_sel;
    wire [4:0] rate_en;
    assign mode_std = fec_mode_cfg_r[7:4];
    assign manual   = scan_control_r[`FVS_SCAN_MANUAL];
    assign avg_sel  = scan_control_r[`FVS_SCAN_AVG_LO+1:`FVS_SCAN_AVG_LO];
    assign to_sel   = scan_control_r[`FVS_SCAN_TO_LO+1:`FVS_SCAN_TO_LO];
    assign hys_sel  = scan_control_r[`FVS_SCAN_HYS_LO+1:`FVS_SCAN_HYS_LO];
    assign rate_en  = puncture_enable_r[4:0];

    // ==========================================
    // search sequencer
    localparam ST_IDLE   = 2'b00;
    localparam ST_SEARCH = 2'b01;
    localparam ST_LOCKED = 2'b10;
    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg  [2:0] rate_r;
    reg  [2:0] rate_nxt;
    reg  [2:0] phase_r;
    reg  [2:0] phase_nxt;
    wire       auto_run;
    wire       timeout;
    wire       restart;
    wire [2:0] phase_last;

    // sync disabled: no search, byte phase frozen
    assign auto_run = sync_word_enable && !manual;
    assign restart  = state_r != ST_SEARCH;
    // bpsk feeds one bit per symbol, iq two: fewer phases to try when paired
    assign phase_last = (mode_std == `FVS_STD_BPSK) ? 3'h7 : 3'h3;

    fvs_search_timer u_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .run       (auto_run),
        .restart   (restart),
        .bit_tick  (bit_tick),
        .limit_sel (to_sel),
        .expired   (timeout)
    );

    // next enabled rate after current, wrapping; stays put if none enabled
    function [2:0] next_rate;
        input [2:0] cur;
        input [4:0] en;
        integer i;
        reg [2:0] c;
        reg [3:0] s;
        reg [3:0] d;
        reg       hit;
        begin
            next_rate = cur;
            hit = 1'b0;
            for (i = 1; i <= `FVS_NUM_RATES; i = i + 1) begin
                // four-bit sum: the wrap past rate 4 must not fold inside three bits
                s = {1'b0, cur} + i[3:0];
                d = s - 4'd5;
                c = (s >= 4'd5) ? d[2:0] : s[2:0];
                if (!hit && en[c]) begin
                    next_rate = c;
                    hit = 1'b1;
                end
            end
        end
    endfunction

    always @* begin
        state_nxt = state_r;
        rate_nxt  = rate_r;
        phase_nxt = phase_r;
        case (state_r)
            ST_IDLE: begin
                if (auto_run) begin
                    state_nxt = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (!auto_run) begin
                    state_nxt = ST_IDLE;
                end else if (sync_found) begin
                    state_nxt = ST_LOCKED;
                end else if (timeout) begin
                    // try every phase, then move to the next enabled rate
                    if (phase_r >= phase_last) begin
                        phase_nxt = 3'h0;
                        rate_nxt  = next_rate(rate_r, rate_en);
                    end else begin
                        phase_nxt = phase_r + 3'h1;
                    end
                end
            end
            ST_LOCKED: begin
                if (!auto_run) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            rate_r  <= 3'h0;
            phase_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            rate_r  <= rate_nxt;
            phase_r <= phase_nxt;
        end
    end

    // ==========================================
    // registered outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            std_sel        <= 4'h0;
            iq_feed        <= 1'b1;
            alt_std        <= 1'b0;
            serial_out     <= 1'b0;
            stream_oe      <= 1'b0;
            vit_level      <= 8'h00;
            rate_sel       <= 3'h0;
            bit_phase      <= 3'h0;
            averaging_span <= 18'h00000;
            sync_hys_max   <= 8'h00;
            sync_block_len <= 8'h00;
            searching      <= 1'b0;
        end else begin
            std_sel        <= mode_std;
            iq_feed        <= (mode_std != `FVS_STD_BPSK);
            alt_std        <= (mode_std == `FVS_STD_ALT);
            serial_out     <= fec_mode_cfg_r[`FVS_MODE_SERIAL];
            stream_oe      <= !fec_mode_cfg_r[`FVS_MODE_HIZ];
            vit_level      <= lvl_eff[rate_r];
            rate_sel       <= rate_r;
            bit_phase      <= phase_r;
            averaging_span <= 18'h00001 << (`FVS_AVG_BASE_LOG2 + {avg_sel, 1'b0});
            sync_hys_max   <= 8'h10 << hys_sel;
            sync_block_len <= (mode_std == `FVS_STD_ALT) ? `FVS_BLK_ALT : `FVS_BLK_QPSK;
            searching      <= (state_r == ST_SEARCH);
        end
    end
endmodule

//--- test/fvs_config_asserts.sv
// assertion checker bound to the fec search config bank
module fvs_config_asserts (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // decoder side
    input wire logic        sync_word_enable,
    input wire logic        sync_found,
    input wire logic [3:0]  std_sel,
    input wire logic        iq_feed,
    input wire logic        alt_std,
    input wire logic        serial_out,
    input wire logic        stream_oe,
    input wire logic [2:0]  rate_sel,
    input wire logic [2:0]  bit_phase,
    input wire logic [17:0] averaging_span,
    input wire logic [7:0]  sync_hys_max,
    input wire logic [7:0]  sync_block_len,
    input wire logic        searching
);
    // ==========================================
    // settle window after reset release
    // the two-stage reset sync delays outputs, so nothing is judged early
    logic [2:0] up_r;
    wire        rdy = (up_r == 3'h7);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) up_r <= 3'h0;
        else if (!rdy) up_r <= up_r + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // properties
    feed_map_a: assert property (rdy |-> iq_feed == (std_sel != 4'h1) && alt_std == (std_sel == 4'h4))
        else $error("feed or standard flag wrong");
    serial_sel_a: assert property (rdy && reg_wr && reg_addr == 8'h28 |-> ##2 serial_out == $past(reg_wdata[1], 2))
        else $error("serial select wrong");
    out_hiz_a: assert property (rdy && reg_wr && reg_addr == 8'h28 |-> ##2 stream_oe == !$past(reg_wdata[0], 2))
        else $error("stream enable wrong");
    span_sel_a: assert property (rdy && reg_wr && reg_addr == 8'h32
        |-> ##2 averaging_span == (18'h400 << {$past(reg_wdata[5:4], 2), 1'b0}))
        else $error("averaging span wrong");
    hys_max_a: assert property (rdy && reg_wr && reg_addr == 8'h32 |-> ##2 sync_hys_max == (8'h10 << $past(reg_wdata[1:0], 2)))
        else $error("hysteresis max wrong");
    block_len_a: assert property (rdy |-> sync_block_len == (alt_std ? 8'h93 : 8'hcc))
        else $error("block length wrong");
    sync_off_a: assert property (rdy && !sync_word_enable [*3] |-> !searching)
        else $error("search runs with sync off");
    frz_hold_a: assert property (rdy && !sync_word_enable [*3] |=> $stable(rate_sel) && $stable(bit_phase))
        else $error("rate or phase moved with sync off");
    idle_hold_a: assert property (rdy && !searching [*2] |=> $stable(rate_sel) && $stable(bit_phase))
        else $error("rate or phase moved while idle");
    lock_stop_a: assert property (rdy && searching && sync_found |-> ##[1:2] !searching)
        else $error("search not stopped on sync");
    unmapped_rd_a: assert property (rdy && reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind fvs_config fvs_config_asserts u_fvs_config_asserts (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .sync_word_enable, .sync_found, .std_sel, .iq_feed, .alt_std, .serial_out, .stream_oe, .rate_sel,
    .bit_phase, .averaging_span, .sync_hys_max, .sync_block_len, .searching);

//--- test/tb.sv
// self-checking bench for the fec search config bank
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // stimulus and design
    logic        clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, md;
    logic        sync_word_enable = 0, bit_tick = 0, sync_found = 0;
    wire  [7:0]  reg_rdata, vit_level, sync_hys_max, sync_block_len;
    wire  [3:0]  std_sel;
    wire  [2:0]  rate_sel, bit_phase;
    wire  [17:0] averaging_span;
    wire         iq_feed, alt_std, serial_out, stream_oe, searching;
    int          err_count = 0, check_count = 0, cyc = 0, seed = 63956, n;
    logic [7:0]  rq[$];
    logic [7:0]  lvl[5] = '{8'h1e, 8'h14, 8'h0f, 8'h09, 8'h05};
    logic [5:0]  rp;
    always #2.5 clk = ~clk;
    fvs_config u_fvs_config (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_word_enable(sync_word_enable), .bit_tick(bit_tick),
        .sync_found(sync_found), .std_sel(std_sel), .iq_feed(iq_feed), .alt_std(alt_std), .serial_out(serial_out),
        .stream_oe(stream_oe), .vit_level(vit_level), .rate_sel(rate_sel), .bit_phase(bit_phase),
        .averaging_span(averaging_span), .sync_hys_max(sync_hys_max), .sync_block_len(sync_block_len),
        .searching(searching));
    // ==========================================
    // compare and bus tasks
    task automatic fail(string m);
        err_count++;
        $display("wrong value at %0t: %0s", $time, m);
    endtask
    task automatic chk(logic [17:0] got, logic [17:0] exp, string m);
        check_count++;
        if (got !== exp) fail(m);
    endtask
    task automatic cmp_rd(logic [7:0] got, logic [7:0] exp);
        check_count++;
        if (got !== exp) fail("read data");
    endtask
    task automatic step(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        step(1);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        step(1);
        reg_rd = 1;
        reg_addr = a;
        rq.push_back(e);
        step(1);
        reg_rd = 0;
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // read results land one cycle after the strobe
    always @(posedge clk) begin
        cyc++;
        if (cyc > 90000) begin
            fail("timeout");
            test_done();
        end else begin
            if (rd_d) cmp_rd(reg_rdata, rq.pop_front());
            rd_d <= reg_rd;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        step(16);
        rst_b = 1;
        step(4);
        chk(stream_oe, 0, "hi-z at reset");
        chk(averaging_span, 18'd4096, "reset span");
        chk(sync_hys_max, 32, "reset hysteresis");
        rd(8'h28, 8'h01);
        for (int i = 0; i < 5; i++) rd(8'h29 + i, lvl[i]);
        rd(8'h31, 8'h1f);
        rd(8'h32, 8'h19);
        rd(8'h30, 8'h00);
        chk(vit_level, lvl[rate_sel], "reset level");
        for (int i = 0; i < 5; i++) begin
            lvl[i] = $random(seed);
            wr(8'h29 + i, lvl[i]);
            rd(8'h29 + i, lvl[i]);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            md = {(i == 1) ? 4'h1 : (i == 2) ? 4'h4 : 4'h0, 2'b00, 2'(i)};
            wr(8'h28, md);
            step(3);
            chk(std_sel, md[7:4], "standard");
            chk(iq_feed, i != 1, "feeding");
            chk(alt_std, i == 2, "alt standard");
            chk(serial_out, md[1], "serial");
            chk(stream_oe, !md[0], "hi-z");
            chk(sync_block_len, (i == 2) ? 147 : 204, "block length");
            rd(8'h28, md);
        end
        for (int i = 0; i < 4; i++) begin
            md = {2'b10, 2'(i), 2'(3 - i), 2'(i)};
            wr(8'h32, md);
            step(3);
            chk(averaging_span, 18'h400 << (2 * i), "span");
            chk(sync_hys_max, 8'h10 << i, "hysteresis");
            rd(8'h32, md);
        end
        $display("test fields done");
        wr(8'h31, 8'h05);
        wr(8'h32, 8'h01);
        sync_word_enable = 1;
        bit_tick = 1;
        step(3);
        chk(searching, 1, "auto search");
        // one step per timeout: four phases, then the next enabled rate
        for (int k = 0; k < 4; k++) begin
            rp = {rate_sel, bit_phase};
            n = 0;
            while ({rate_sel, bit_phase} === rp && n < 17000) begin
                step(1);
                n++;
            end
            chk(n > 16200 && n < 16500, 1, "timeout span");
        end
        chk(rate_sel, 2, "next enabled rate");
        chk(bit_phase, 0, "phase wrap");
        chk(vit_level, lvl[2], "rate level");
        $display("test search done");
        // go manual just before the next timeout would step the phase
        rp = {rate_sel, bit_phase};
        step(16300);
        wr(8'h32, 8'h81);
        step(300);
        chk({rate_sel, bit_phase}, rp, "manual hold");
        chk(searching, 0, "manual idle");
        sync_word_enable = 0;
        wr(8'h32, 8'h01);
        step(300);
        chk({rate_sel, bit_phase}, rp, "sync off hold");
        chk(searching, 0, "sync off idle");
        sync_word_enable = 1;
        step(3);
        chk(searching, 1, "search resumes");
        sync_found = 1;
        step(1);
        sync_found = 0;
        step(2);
        chk(searching, 0, "lock");
        $display("test hold done");
        test_done();
    end
endmodule
